/* File: core/swl_map.svh */
`ifndef SWL_MAP_SVH
`define SWL_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SWL_OFF_CTRL      8'h00
`define SWL_OFF_CMD       8'h04
`define SWL_OFF_TIM0      8'h08
`define SWL_OFF_TIM1      8'h0C
`define SWL_OFF_STATUS    8'h10

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define SWL_CTRL_IF_SUP   0
`define SWL_CTRL_TRG_SUP  1
`define SWL_CTRL_VPP_GEN  2
`define SWL_CTRL_VPP_APP  3
`define SWL_CTRL_FLASH    4
`define SWL_CTRL_RST      5
`define SWL_CTRL_NO_RPIN  6
`define SWL_CTRL_SAMPLE   7
`define SWL_CTRL_RESET    32'h0000_0000

// ----------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------
`define SWL_CMD_BIT       0
`define SWL_CMD_RX        1
`define SWL_CMD_LAST      2

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define SWL_ST_BUSY       0
`define SWL_ST_RXBIT      1
`define SWL_ST_RXVAL      2
`define SWL_ST_IF_FLT     3
`define SWL_ST_TRG_FLT    4
`define SWL_ST_PWR_OK     5
`define SWL_ST_RST_SNS    6
`define SWL_ST_CFG_DONE   7
`define SWL_ST_SUSPEND    8
`define SWL_ST_IF_ON      9
`define SWL_ST_TRG_ON     10
`define SWL_ST_REFUSED    11
`define SWL_ST_WIDTH_LSB  16

// ----------------------------------------------------------------
// timing: fields hold counts of 24 MHz link ticks (41.67 ns each)
// ----------------------------------------------------------------
`define SWL_CLK_MHZ       100
`define SWL_LINK_MHZ      24
`define SWL_TIM0_RESET    32'h0614_0D04
`define SWL_TIM1_RESET    32'h000A_1404

`endif

/* File: core/swl_pkg.sv */
package swl_pkg;

	// ----------------------------------------------------------------
	// bit engine states
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE     = 5'b00001,
		ST_TX_LOW   = 5'b00010,
		ST_TX_HIGH  = 5'b00100,
		ST_RX_START = 5'b01000,
		ST_RX_WIN   = 5'b10000
	} swl_state_t;

endpackage : swl_pkg

/* File: core/swl_sync.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-flop synchroniser for pin levels
// ----------------------------------------------------------------
module swl_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule : swl_sync

/* File: core/swl_axil.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// axi4-lite slave handshake; register decode lives in the parent
// ----------------------------------------------------------------
module swl_axil #(
	parameter int AW = 8
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic               wr_en,
	output logic [AW-1:0]      wr_addr,
	output logic [31:0]        wr_data,
	output logic [3:0]         wr_strb,
	input  wire logic          wr_hit,
	input  wire logic [31:0]   rd_data,
	input  wire logic          rd_hit
);

	logic aw_held;
	logic w_held;

	// write commits once both halves are held and no response is pending
	assign wr_en = aw_held & w_held & ~s_axi_bvalid;

	// address and data are accepted in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			wr_addr       <= '0;
			wr_data       <= 32'h0000_0000;
			wr_strb       <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held       <= 1'b1;
				s_axi_awready <= 1'b0;
				wr_addr       <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held       <= 1'b1;
				s_axi_wready <= 1'b0;
				wr_data      <= s_axi_wdata;
				wr_strb      <= s_axi_wstrb;
			end
			if (wr_en) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2; // slverr when unmapped
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// read data is captured with the address, answered next cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_hit ? rd_data : 32'h0000_0000;
			s_axi_rresp   <= rd_hit ? 2'h0 : 2'h2;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule : swl_axil

/* File: core/swl_top.sv */
// Operation
// - link timing steps at 24 MHz resolution
// - direction high transmits, low receives
// - direction rests low when idle
// - direction stays high between transmit bits of a command
// - receive bit drives only the start pulse
// - transmit bit is one low pulse, width-coded
// - receive bit: start pulse, then reply window
// - capture mode decodes bit from low width
// - sample mode reads the line level instead
// - supplies off at connect, interface before target
// - each supply fault visible to software
// - a fault turns its supply off
// - supplies need negotiation, drop on suspend
// - no link start unless target powered
// - programming generator has separate enable
// - programming voltage applied only in flash sequence
// - reset drive output, reset sense readable unchanged
// - pinless targets get no reset pin drive
// - link stays idle while another port active
// - reset drive active high
`timescale 1ns/1ps
`include "swl_map.svh"

module swl_top #(
	parameter int AW = 8,
	parameter int CW = 8
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic               link_direction_ctl,
	output logic               link_drive_out,
	input  wire logic          link_sense_in,
	output logic               interface_supply_en,
	output logic               target_supply_en,
	input  wire logic          interface_supply_fault,
	input  wire logic          target_supply_fault,
	input  wire logic          host_config_done,
	input  wire logic          host_suspend,
	input  wire logic          target_half_supply_ok,
	input  wire logic          other_port_active,
	output logic               vpp_gen_on,
	output logic               vpp_apply_en,
	output logic               target_reset_drive,
	input  wire logic          target_reset_sense
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic sense_s;
	logic if_flt_s;
	logic trg_flt_s;
	logic cfg_s;
	logic susp_s;
	logic pwr_ok_s;
	logic other_s;
	logic rst_sns_s;

	swl_sync #(.W(8)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({link_sense_in, interface_supply_fault, target_supply_fault,
		           host_config_done, host_suspend, target_half_supply_ok,
		           other_port_active, target_reset_sense}),
		.q       ({sense_s, if_flt_s, trg_flt_s, cfg_s, susp_s, pwr_ok_s,
		           other_s, rst_sns_s})
	);

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [31:0]   wr_data;
	logic [3:0]    wr_strb;
	logic          wr_hit;
	logic [31:0]   rd_data;
	logic          rd_hit;

	swl_axil #(.AW(AW)) u_axil (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_hit        (wr_hit),
		.rd_data       (rd_data),
		.rd_hit        (rd_hit)
	);

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] swl_merge(input logic [31:0] old_v,
	                                          input logic [31:0] new_v,
	                                          input logic [3:0]  strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : swl_merge

	// known offset check, shared by both decode paths
	function automatic logic swl_mapped(input logic [AW-1:0] a);
		return (a == AW'(`SWL_OFF_CTRL)) || (a == AW'(`SWL_OFF_CMD))
		    || (a == AW'(`SWL_OFF_TIM0)) || (a == AW'(`SWL_OFF_TIM1))
		    || (a == AW'(`SWL_OFF_STATUS));
	endfunction : swl_mapped

	assign wr_hit = swl_mapped(wr_addr);
	assign rd_hit = swl_mapped(s_axi_araddr);

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	logic [31:0] ctrl;
	logic [31:0] tim0;
	logic [31:0] tim1;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= `SWL_CTRL_RESET; // supplies start off
			tim0 <= `SWL_TIM0_RESET;
			tim1 <= `SWL_TIM1_RESET;
		end else if (wr_en) begin
			if (wr_addr == AW'(`SWL_OFF_CTRL)) ctrl <= swl_merge(ctrl, wr_data, wr_strb);
			if (wr_addr == AW'(`SWL_OFF_TIM0)) tim0 <= swl_merge(tim0, wr_data, wr_strb);
			if (wr_addr == AW'(`SWL_OFF_TIM1)) tim1 <= swl_merge(tim1, wr_data, wr_strb);
		end
	end

	wire          sample_mode = ctrl[`SWL_CTRL_SAMPLE];
	wire [CW-1:0] one_low     = tim0[7:0];
	wire [CW-1:0] zero_low    = tim0[15:8];
	wire [CW-1:0] bit_period  = tim0[23:16];
	wire [CW-1:0] sample_off  = tim0[31:24];
	wire [CW-1:0] start_len   = tim1[7:0];
	wire [CW-1:0] win_len     = tim1[15:8];
	wire [CW-1:0] width_thr   = tim1[23:16];

	// ----------------------------------------------------------------
	// link tick: 24 of every 100 clocks, evenly spread
	// ----------------------------------------------------------------
	logic [6:0] tick_acc;
	logic       tick;

	// fractional divider keeps the long-run rate exact at 24 MHz
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_acc <= 7'h00;
			tick     <= 1'b0;
		end else if (tick_acc + 7'(`SWL_LINK_MHZ) >= 7'(`SWL_CLK_MHZ)) begin
			tick_acc <= tick_acc + 7'(`SWL_LINK_MHZ) - 7'(`SWL_CLK_MHZ);
			tick     <= 1'b1;
		end else begin
			tick_acc <= tick_acc + 7'(`SWL_LINK_MHZ);
			tick     <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// supply sequencing and faults
	// ----------------------------------------------------------------
	logic if_flt;
	logic trg_flt;
	logic refused;
	wire  st_wr = wr_en && wr_addr == AW'(`SWL_OFF_STATUS) && wr_strb[0];

	// sticky faults; a fault in the clearing cycle stays set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			if_flt  <= 1'b0;
			trg_flt <= 1'b0;
		end else begin
			if_flt  <= if_flt_s | (if_flt & ~(st_wr & wr_data[`SWL_ST_IF_FLT]));
			trg_flt <= trg_flt_s | (trg_flt & ~(st_wr & wr_data[`SWL_ST_TRG_FLT]));
		end
	end

	// target supply only follows an enabled interface supply
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interface_supply_en <= 1'b0;
			target_supply_en    <= 1'b0;
		end else begin
			interface_supply_en <= ctrl[`SWL_CTRL_IF_SUP] & cfg_s & ~susp_s
			                     & ~if_flt_s & ~if_flt;
			target_supply_en    <= ctrl[`SWL_CTRL_TRG_SUP] & interface_supply_en
			                     & cfg_s & ~susp_s
			                     & ~trg_flt_s & ~trg_flt;
		end
	end

	// ----------------------------------------------------------------
	// programming voltage and target reset
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vpp_gen_on         <= 1'b0;
			vpp_apply_en       <= 1'b0;
			target_reset_drive <= 1'b0;
		end else begin
			vpp_gen_on   <= ctrl[`SWL_CTRL_VPP_GEN] & interface_supply_en;
			vpp_apply_en <= ctrl[`SWL_CTRL_VPP_APP] & ctrl[`SWL_CTRL_FLASH]
			              & ctrl[`SWL_CTRL_VPP_GEN] & interface_supply_en;
			// pinless targets: reset pin drive is held off
			target_reset_drive <= ctrl[`SWL_CTRL_RST] & ~ctrl[`SWL_CTRL_NO_RPIN];
		end
	end

	// ----------------------------------------------------------------
	// bit engine
	// ----------------------------------------------------------------
	swl_pkg::swl_state_t state;
	logic [CW-1:0]       cnt;
	logic [CW-1:0]       width;
	logic                tx_bit;
	logic                last_bit;
	logic                rx_bit;
	logic                rx_val;
	logic                smp_bit;

	wire cmd_wr  = wr_en && wr_addr == AW'(`SWL_OFF_CMD);
	wire link_ok = pwr_ok_s & interface_supply_en & ~other_s;
	wire go      = cmd_wr && state == swl_pkg::ST_IDLE && link_ok;
	wire [CW-1:0] cnt_n   = cnt + CW'(1);
	wire [CW-1:0] low_len = tx_bit ? one_low : zero_low;
	wire [CW-1:0] width_n = width + CW'(!sense_s); // logical not stays one bit wide

	// a start that cannot run is flagged; set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			refused <= 1'b0;
		end else begin
			refused <= (cmd_wr & ~go)
			         | (refused & ~(st_wr & wr_data[`SWL_ST_REFUSED]));
		end
	end

	// one bit per command write; line idles high, driver off except between transmit bits of a command
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state              <= swl_pkg::ST_IDLE;
			cnt                <= '0;
			width              <= '0;
			tx_bit             <= 1'b0;
			last_bit           <= 1'b0;
			rx_bit             <= 1'b0;
			rx_val             <= 1'b0;
			smp_bit            <= 1'b0;
			link_direction_ctl <= 1'b0;
			link_drive_out     <= 1'b1;
		end else if (other_s) begin
			state              <= swl_pkg::ST_IDLE;
			link_direction_ctl <= 1'b0;
			link_drive_out     <= 1'b1;
		end else begin
			unique case (state)
				swl_pkg::ST_IDLE: begin
					if (go) begin
						cnt                <= '0;
						rx_val             <= 1'b0;
						tx_bit             <= wr_data[`SWL_CMD_BIT];
						last_bit           <= wr_data[`SWL_CMD_LAST];
						link_direction_ctl <= 1'b1;
						link_drive_out     <= 1'b0;
						state <= wr_data[`SWL_CMD_RX] ? swl_pkg::ST_RX_START
						                              : swl_pkg::ST_TX_LOW;
					end
				end
				swl_pkg::ST_TX_LOW: begin
					if (tick) begin
						cnt <= cnt_n;
						if (cnt_n >= low_len) begin
							link_drive_out <= 1'b1;
							state          <= swl_pkg::ST_TX_HIGH;
						end
					end
				end
				swl_pkg::ST_TX_HIGH: begin
					if (tick) begin
						cnt <= cnt_n;
						if (cnt_n >= bit_period) begin
							link_direction_ctl <= ~last_bit;
							state              <= swl_pkg::ST_IDLE;
						end
					end
				end
				swl_pkg::ST_RX_START: begin
					if (tick) begin
						cnt <= cnt_n;
						if (cnt_n >= start_len) begin
							link_direction_ctl <= 1'b0;
							link_drive_out     <= 1'b1;
							cnt                <= '0;
							width              <= '0;
							state              <= swl_pkg::ST_RX_WIN;
						end
					end
				end
				swl_pkg::ST_RX_WIN: begin
					if (tick) begin
						cnt   <= cnt_n;
						width <= width_n;
						if (cnt == sample_off) smp_bit <= sense_s;
						if (cnt_n >= win_len) begin
							rx_val  <= 1'b1;
							state   <= swl_pkg::ST_IDLE;
							if (sample_mode) begin
								rx_bit <= (cnt == sample_off) ? sense_s : smp_bit;
							end else begin
								rx_bit <= (width_n < width_thr);
							end
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	logic [31:0] status;

	always_comb begin
		status                    = 32'h0000_0000;
		status[`SWL_ST_BUSY]      = state != swl_pkg::ST_IDLE;
		status[`SWL_ST_RXBIT]     = rx_bit;
		status[`SWL_ST_RXVAL]     = rx_val;
		status[`SWL_ST_IF_FLT]    = if_flt;
		status[`SWL_ST_TRG_FLT]   = trg_flt;
		status[`SWL_ST_PWR_OK]    = pwr_ok_s;
		status[`SWL_ST_RST_SNS]   = rst_sns_s;
		status[`SWL_ST_CFG_DONE]  = cfg_s;
		status[`SWL_ST_SUSPEND]   = susp_s;
		status[`SWL_ST_IF_ON]     = interface_supply_en;
		status[`SWL_ST_TRG_ON]    = target_supply_en;
		status[`SWL_ST_REFUSED]   = refused;
		status[`SWL_ST_WIDTH_LSB +: CW] = width;
		unique case (s_axi_araddr)
			AW'(`SWL_OFF_CTRL):   rd_data = ctrl;
			AW'(`SWL_OFF_TIM0):   rd_data = tim0;
			AW'(`SWL_OFF_TIM1):   rd_data = tim1;
			AW'(`SWL_OFF_STATUS): rd_data = status;
			default:              rd_data = 32'h0000_0000; // cmd reads zero
		endcase
	end

endmodule : swl_top

/* File: testbench/swl_chk.sv */
`timescale 1ns/1ps

module swl_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic link_direction_ctl,
	input wire logic link_drive_out,
	input wire logic interface_supply_en,
	input wire logic target_supply_en,
	input wire logic interface_supply_fault,
	input wire logic host_suspend,
	input wire logic target_half_supply_ok,
	input wire logic other_port_active,
	input wire logic vpp_gen_on,
	input wire logic vpp_apply_en
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// --------
	// link pins
	// --------
	property p_drive_dir;
		!link_drive_out |-> link_direction_ctl;
	endproperty
	a_drive_dir: assert property (p_drive_dir) else $error("line low while released");
	// a pulse shorter than one tick means a broken count
	property p_pulse;
		$fell(link_drive_out) |=> !link_drive_out [*3];
	endproperty
	a_pulse: assert property (p_pulse) else $error("drive pulse too short");
	property p_start;
		$rose(link_direction_ctl) |-> interface_supply_en && $past(target_half_supply_ok, 3);
	endproperty
	a_start: assert property (p_start) else $error("link started unpowered");
	property p_abort;
		other_port_active [*4] |=> !link_direction_ctl && link_drive_out;
	endproperty
	a_abort: assert property (p_abort) else $error("link busy beside other port");

	// --------
	// supplies, programming voltage and write handshake
	// --------
	property p_trg_if;
		target_supply_en |-> $past(interface_supply_en);
	endproperty
	a_trg_if: assert property (p_trg_if) else $error("target supply ahead");
	property p_if_fault;
		$rose(interface_supply_fault) |-> ##[1:4] !interface_supply_en;
	endproperty
	a_if_fault: assert property (p_if_fault) else $error("fault left supply on");
	property p_suspend;
		host_suspend [*4] |-> ##2 (!interface_supply_en && !target_supply_en);
	endproperty
	a_suspend: assert property (p_suspend) else $error("supply on in suspend");
	property p_vpp;
		vpp_apply_en |-> vpp_gen_on;
	endproperty
	a_vpp: assert property (p_vpp) else $error("vpp applied without generator");
	property p_wsingle;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wsingle: assert property (p_wsingle) else $error("second write taken early");
endmodule : swl_chk

bind swl_top swl_chk swl_chk_inst (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .link_direction_ctl, .link_drive_out, .interface_supply_en,
	.target_supply_en, .interface_supply_fault, .host_suspend, .target_half_supply_ok,
	.other_port_active, .vpp_gen_on, .vpp_apply_en);

/* File: testbench/swl_target_model.sv */
`timescale 1ns/1ps

module swl_target_model (
	input  wire logic       aclk,
	input  wire logic       link_direction_ctl,
	input  wire logic       link_drive_out,
	input  wire logic [7:0] reply_len,
	input  wire logic [7:0] reply_dly,
	output logic            link_sense_in
);
	logic [7:0] age = 8'h00;

	// cycles since the host released the line; saturates so it never wraps
	always_ff @(posedge aclk) begin
		if ($fell(link_direction_ctl))
			age <= 8'h01;
		else if (age != 8'h00 && age != 8'hFF)
			age <= age + 8'h01;
	end

	// host drives while direction is high; else pull-up unless target pulls low
	assign link_sense_in = link_direction_ctl ? link_drive_out
		: !(age > reply_dly && age <= reply_dly + reply_len);
endmodule : swl_target_model

/* File: testbench/swl_top_test.sv */
`timescale 1ns/1ps
`include "swl_map.svh"

module swl_top_test;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        link_direction_ctl, link_drive_out, link_sense_in;
	logic        interface_supply_en, target_supply_en, vpp_gen_on, vpp_apply_en;
	logic        interface_supply_fault = 1'b0, target_supply_fault = 1'b0;
	logic        host_config_done = 1'b0, host_suspend = 1'b0, target_reset_drive;
	logic        target_half_supply_ok = 1'b0, other_port_active = 1'b0;
	logic        target_reset_sense = 1'b0;
	logic [7:0]  reply_len = 8'h0C, reply_dly = 8'h02, c;
	logic [31:0] rnd = 32'h0000_B1CC;
	int          err_count = 0, check_count = 0, low_w = 0, lc = 0, t;

	swl_top swl_top_inst (.*);
	swl_target_model swl_target_model_inst (.*);

	always #5 aclk = ~aclk;

	// width of the last low drive pulse, in clocks
	always @(posedge aclk) begin
		lc <= link_drive_out ? 0 : lc + 1;
		if (link_drive_out && lc != 0)
			low_w <= lc;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// first tick lands anywhere in its period: allow one tick short, two clocks long
	function automatic logic near(input int w, input int tk);
		return w >= (tk - 1) * `SWL_CLK_MHZ / `SWL_LINK_MHZ
			&& w <= tk * `SWL_CLK_MHZ / `SWL_LINK_MHZ + 2;
	endfunction : near

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude();
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	// write: both channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid);
		do @(posedge aclk); while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd_reg(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd_reg

	// one link bit, then poll busy; a hang is ended by the watchdog
	task automatic bit_op(input logic [31:0] cmd);
		wr(`SWL_OFF_CMD, cmd);
		do rd_reg(`SWL_OFF_STATUS);
		while (rd[`SWL_ST_BUSY]);
	endtask : bit_op

	// watchdog: several times the expected run length
	initial begin
		#200000;
		err_count++;
		conclude();
	end

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		chk({26'h0, link_direction_ctl, link_drive_out, interface_supply_en, target_supply_en,
			vpp_gen_on, target_reset_drive}, 32'h10);
		rd_reg(`SWL_OFF_TIM0);
		chk(rd, `SWL_TIM0_RESET);
		rd_reg(`SWL_OFF_TIM1);
		chk(rd, `SWL_TIM1_RESET);
		rd_reg(`SWL_OFF_CTRL);
		chk(rd, `SWL_CTRL_RESET);
		rd_reg(8'h14);
		chk({rd[29:0], rsp}, 32'h2);
		wr(8'h20, 32'hFFFF_FFFF);
		chk({30'h0, rsp}, 32'h2);
		// unpowered target: command refused, line untouched
		bit_op(32'h1);
		chk({30'h0, rd[`SWL_ST_REFUSED], link_direction_ctl}, 32'h2);
		wr(`SWL_OFF_STATUS, 32'h800);
		host_config_done <= 1'b1;
		target_half_supply_ok <= 1'b1;
		wr(`SWL_OFF_CTRL, 32'h3);
		repeat (8) @(posedge aclk);
		chk({30'h0, interface_supply_en, target_supply_en}, 32'h3);
		// random transmit bits, the last one ends the command
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			t = rnd[0] ? `SWL_TIM0_RESET & 32'hFF : (`SWL_TIM0_RESET >> 8) & 32'hFF;
			bit_op({29'h0, i == 7, 1'b0, rnd[0]});
			chk({31'h0, near(low_w, t)}, 32'h1);
			chk({31'h0, link_direction_ctl}, {31'h0, i != 7});
		end
		// receive in capture then sample mode, fast and slow replies
		for (int m = 0; m < 2; m++) begin
			wr(`SWL_OFF_CTRL, {24'h0, m[0], 7'h03});
			for (int i = 0; i < 6; i++) begin
				rnd = lfsr(rnd);
				reply_len <= rnd[0] ? 8'h0C : 8'h3C;
				reply_dly <= {6'h0, rnd[2:1]} + 8'h01;
				bit_op(32'h6);
				chk({30'h0, rd[2:1]}, {30'h0, 1'b1, rnd[0]});
				chk({31'h0, link_direction_ctl}, 32'h0);
			end
		end
		other_port_active <= 1'b1;
		bit_op(32'h1);
		chk({30'h0, rd[`SWL_ST_REFUSED], link_direction_ctl}, 32'h2);
		wr(`SWL_OFF_STATUS, 32'h800);
		other_port_active <= 1'b0;
		// a fault latches and holds the supply off until cleared
		interface_supply_fault <= 1'b1;
		target_supply_fault <= 1'b1;
		repeat (6) @(posedge aclk);
		chk({30'h0, interface_supply_en, target_supply_en}, 32'h0);
		interface_supply_fault <= 1'b0;
		target_supply_fault <= 1'b0;
		rd_reg(`SWL_OFF_STATUS);
		chk({30'h0, rd[`SWL_ST_IF_FLT], rd[`SWL_ST_TRG_FLT]}, 32'h3);
		chk({31'h0, interface_supply_en}, 32'h0);
		wr(`SWL_OFF_STATUS, 32'h18);
		host_suspend <= 1'b1;
		repeat (8) @(posedge aclk);
		chk({30'h0, interface_supply_en, target_supply_en}, 32'h0);
		host_suspend <= 1'b0;
		// random control words against the enables they imply
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			c = {1'b0, rnd[6:1], 1'b1};
			target_reset_sense <= rnd[7];
			wr(`SWL_OFF_CTRL, {24'h0, c});
			repeat (8) @(posedge aclk);
			chk({28'h0, target_supply_en, vpp_gen_on, vpp_apply_en, target_reset_drive},
				{28'h0, c[1], c[2], &c[4:2], c[5] & !c[6]});
			rd_reg(`SWL_OFF_STATUS);
			chk({31'h0, rd[`SWL_ST_RST_SNS]}, {31'h0, rnd[7]});
		end
		conclude();
	end
endmodule : swl_top_test
